// File: hw/tcu_defs.svh
// Constants for the 8-bit timer with two compare channels.
// Assumes inclusion by bare name from the package or module.
`ifndef TCU_DEFS_SVH
`define TCU_DEFS_SVH
`define TCU_BOTTOM      8'h00
`define TCU_MAX         8'hff
`define TCU_CS_STOP     3'h0
`define TCU_COM_NONE    2'h0
`define TCU_COM_TOGGLE  2'h1
`define TCU_COM_CLEAR   2'h2
`define TCU_COM_SET     2'h3
`define TCU_WM_NORMAL   3'h0
`define TCU_WM_PCPWM    3'h1
`define TCU_WM_CTC      3'h2
`define TCU_WM_FPWM     3'h3
`define TCU_WM_PCPWM_A  3'h5
`define TCU_WM_FPWM_A   3'h7
`define TCU_FLAG_OVF    0
`define TCU_FLAG_CMPA   1
`define TCU_FLAG_CMPB   2
`endif

// File: hw/tcu_pkg.sv
// Types for the 8-bit timer with two compare channels.
// Assumes tcu_defs.svh is on the include path.
package tcu_pkg;
`include "tcu_defs.svh"
    typedef logic [7:0] tcu_byte_type;
    typedef logic [2:0] tcu_flags_type;
endpackage

// File: hw/tcu_timer8.sv
// 8-bit timer/counter with two compare channels and flags.
// Assumes the register strobes come from logic on clk_in; the crystal
// oscillator pin is outside the domain and is synchronised here.
// Functional notes
// - Eight-bit counter and two compare values compared every cycle.
// - Match asserted whenever counter equals a channel compare value.
// - Clock select zero produces no tick; counter stays stopped.
// - Tick from I/O clock by default; async select uses oscillator pin.
// - Counter readable anytime, writable unless power reduction bit set; write beats clear and count.
// - Each tick clears, increments or decrements per three-bit wave mode.
// - Bottom 0x00, max 0xFF; top is max or compare A by mode.
// - Compare match sets that channel flag on the next tick.
// - Flags clear on interrupt service or by writing one.
// - Flags visible together; each interrupt gated by its mask bit.
// - Overflow flag set where the wave mode defines overflow.
// - In PWM modes compare writes buffer, load at top or bottom.
// - Normal and CTC modes write compare values directly.
// - Force strobe in non-PWM acts on output only, no flag or clear.
// - Counter write blocks every match in the following tick.
// - Compare output registers keep value when wave mode changes.
// - Compare output mode bits act immediately, unbuffered.
// - Output mode zero leaves compare output unchanged on match.
// - Normal mode counts up, wraps, sets overflow when reaching zero.
`timescale 1ns/1ns
module tcu_timer8
    import tcu_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    input  wire logic          power_reduce_bit_in,
    input  wire logic          async_clock_select_in,
    input  wire logic          osc_pin_in,
    input  wire logic [2:0]    clock_select_field_in,
    input  wire logic [2:0]    wave_mode_field_in,
    input  wire logic [1:0]    compare_output_mode_a_in,
    input  wire logic [1:0]    compare_output_mode_b_in,
    input  wire logic          count_wr_in,
    input  wire tcu_byte_type  count_wdata_in,
    input  wire logic          cmp_a_wr_in,
    input  wire logic          cmp_b_wr_in,
    input  wire tcu_byte_type  cmp_wdata_in,
    input  wire logic          force_compare_strobe_a_in,
    input  wire logic          force_compare_strobe_b_in,
    input  wire logic          flag_wr_in,
    input  wire tcu_flags_type flag_wdata_in,
    input  wire tcu_flags_type irq_ack_in,
    input  wire logic          mask_wr_in,
    input  wire tcu_flags_type mask_wdata_in,
    output tcu_byte_type       count_value_out,
    output tcu_byte_type       compare_value_a_out,
    output tcu_byte_type       compare_value_b_out,
    output tcu_flags_type      timer_flag_reg_out,
    output tcu_flags_type      timer_mask_reg_out,
    output logic [2:0]         irq_out,
    output logic               compare_out_a_out,
    output logic               compare_out_b_out
);
    tcu_byte_type  count_q;
    tcu_byte_type  ocr_a_q;
    tcu_byte_type  ocr_b_q;
    tcu_byte_type  buf_a_q;
    tcu_byte_type  buf_b_q;
    tcu_flags_type flag_q;
    tcu_flags_type mask_q;
    logic          dir_down_q;
    logic          block_q;
    logic          match_a_q;
    logic          match_b_q;
    logic          oc_a_q;
    logic          oc_b_q;
    logic [1:0]    osc_sync_q;
    logic          osc_last_q;
    logic          enabled;
    logic          pwm_mode;
    logic          dual_slope;
    logic          top_is_a;
    logic          tick;
    logic          osc_rise;
    logic          at_top;
    logic          at_bottom;
    logic          match_a;
    logic          match_b;
    logic          cmp_a_event;
    logic          cmp_b_event;
    logic          fpwm_clear;
    logic          load_buffers;
    tcu_byte_type  top_val;
    tcu_byte_type  count_d;
    tcu_flags_type flag_set;

    // Output mode action on a match; zero keeps the level
    function automatic logic oc_next(input logic cur, input logic [1:0] com,
                                     input logic pwm, input logic up);
        logic r;
        r = cur;
        case (com)
            `TCU_COM_NONE:   r = cur;
            `TCU_COM_TOGGLE: r = pwm ? cur : ~cur;
            `TCU_COM_CLEAR:  r = pwm ? ~up : 1'b0;
            `TCU_COM_SET:    r = pwm ? up : 1'b1;
            default:         r = cur;
        endcase
        return r;
    endfunction

    // Mode decoding
    assign enabled    = ~power_reduce_bit_in;
    assign pwm_mode   = wave_mode_field_in[0];
    assign dual_slope = pwm_mode & ~wave_mode_field_in[1];
    assign top_is_a   = wave_mode_field_in[2]
                      | (wave_mode_field_in == `TCU_WM_CTC);
    assign top_val    = top_is_a ? ocr_a_q : `TCU_MAX;

    // Oscillator pin passes two flops before the edge detector
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            osc_sync_q <= 2'h0;
            osc_last_q <= 1'b0;
        end else begin
            osc_sync_q <= {osc_sync_q[0], osc_pin_in};
            osc_last_q <= osc_sync_q[1];
        end
    end
    assign osc_rise = osc_sync_q[1] & ~osc_last_q;

    // Prescaling is not modelled: any nonzero select ticks at source rate
    assign tick = enabled
                & (clock_select_field_in != `TCU_CS_STOP)
                & (async_clock_select_in ? osc_rise : 1'b1);

    assign at_top    = (count_q == top_val);
    assign at_bottom = (count_q == `TCU_BOTTOM);
    assign match_a   = (count_q == ocr_a_q);
    assign match_b   = (count_q == ocr_b_q);
    assign cmp_a_event = tick & match_a & ~block_q;
    assign cmp_b_event = tick & match_b & ~block_q;
    assign load_buffers = tick & (dual_slope ? at_top : at_bottom);

    // Counter next value
    always_comb begin
        count_d = count_q;
        if (dual_slope) begin
            if (dir_down_q && !at_bottom) begin
                count_d = count_q - 8'h01;
            end else if (!dir_down_q && at_top) begin
                count_d = count_q - 8'h01;
            end else begin
                count_d = count_q + 8'h01;
            end
        end else if (top_is_a && at_top) begin
            count_d = `TCU_BOTTOM;
        end else begin
            count_d = count_q + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_q    <= `TCU_BOTTOM;
            dir_down_q <= 1'b0;
        end else if (count_wr_in && enabled) begin
            count_q <= count_wdata_in;
        end else if (tick) begin
            count_q <= count_d;
            if (dual_slope && at_top) begin
                dir_down_q <= 1'b1;
            end else if (!dual_slope || at_bottom) begin
                dir_down_q <= 1'b0;
            end
        end
    end

    // Block lasts until the tick after the write, even while stopped
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            block_q <= 1'b0;
        end else if (count_wr_in && enabled) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // Compare values with double buffering in PWM modes
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ocr_a_q <= `TCU_BOTTOM;
            ocr_b_q <= `TCU_BOTTOM;
            buf_a_q <= `TCU_BOTTOM;
            buf_b_q <= `TCU_BOTTOM;
        end else begin
            if (cmp_a_wr_in && enabled) begin
                buf_a_q <= cmp_wdata_in;
            end
            if (cmp_b_wr_in && enabled) begin
                buf_b_q <= cmp_wdata_in;
            end
            if (!pwm_mode) begin
                if (cmp_a_wr_in && enabled) begin
                    ocr_a_q <= cmp_wdata_in;
                end
                if (cmp_b_wr_in && enabled) begin
                    ocr_b_q <= cmp_wdata_in;
                end
            end else if (load_buffers) begin
                ocr_a_q <= buf_a_q;
                ocr_b_q <= buf_b_q;
            end
        end
    end

    // Match latched so the flag rises on the next tick
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            match_a_q <= 1'b0;
            match_b_q <= 1'b0;
        end else if (tick) begin
            match_a_q <= match_a & ~block_q;
            match_b_q <= match_b & ~block_q;
        end
    end

    always_comb begin
        flag_set = 3'h0;
        flag_set[`TCU_FLAG_CMPA] = tick & match_a_q;
        flag_set[`TCU_FLAG_CMPB] = tick & match_b_q;
        if (dual_slope) begin
            flag_set[`TCU_FLAG_OVF] = tick & at_bottom & dir_down_q;
        end else if (pwm_mode) begin
            flag_set[`TCU_FLAG_OVF] = tick & at_top;
        end else begin
            flag_set[`TCU_FLAG_OVF] = tick & (count_d == `TCU_BOTTOM)
                                    & (count_q == `TCU_MAX);
        end
    end

    // A set in the same cycle as a clear wins
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flag_q <= 3'h0;
        end else begin
            flag_q <= (flag_q & ~irq_ack_in
                       & ~(flag_wr_in ? flag_wdata_in : 3'h0))
                    | flag_set;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mask_q <= 3'h0;
        end else if (mask_wr_in && enabled) begin
            mask_q <= mask_wdata_in;
        end
    end

    // Output levels survive mode changes; mode bits act unbuffered
    assign fpwm_clear = pwm_mode & ~dual_slope & tick & at_top;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            oc_a_q <= 1'b0;
            oc_b_q <= 1'b0;
        end else begin
            if ((force_compare_strobe_a_in && !pwm_mode && enabled)
                    || cmp_a_event) begin
                oc_a_q <= oc_next(oc_a_q, compare_output_mode_a_in,
                                  pwm_mode, dir_down_q);
            end else if (fpwm_clear
                    && compare_output_mode_a_in[1]) begin
                oc_a_q <= ~compare_output_mode_a_in[0];
            end
            if ((force_compare_strobe_b_in && !pwm_mode && enabled)
                    || cmp_b_event) begin
                oc_b_q <= oc_next(oc_b_q, compare_output_mode_b_in,
                                  pwm_mode, dir_down_q);
            end else if (fpwm_clear
                    && compare_output_mode_b_in[1]) begin
                oc_b_q <= ~compare_output_mode_b_in[0];
            end
        end
    end

    assign count_value_out     = count_q;
    assign compare_value_a_out = pwm_mode ? buf_a_q : ocr_a_q;
    assign compare_value_b_out = pwm_mode ? buf_b_q : ocr_b_q;
    assign timer_flag_reg_out  = flag_q;
    assign timer_mask_reg_out  = mask_q;
    assign irq_out             = flag_q & mask_q;
    assign compare_out_a_out   = oc_a_q;
    assign compare_out_b_out   = oc_b_q;

    a_flag_next_tick: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        (tick && match_a && !block_q) ##1 tick
        |=> flag_q[`TCU_FLAG_CMPA]) else $error("flag A late");
    a_stop_holds: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (clock_select_field_in == `TCU_CS_STOP && !count_wr_in)
        |=> $stable(count_q)) else $error("stopped counter moved");
    a_write_wins: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (count_wr_in && enabled) |=> count_q == $past(count_wdata_in))
        else $error("counter write lost");
    a_write_blocks: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (count_wr_in && enabled) |=> !cmp_a_event && !cmp_b_event)
        else $error("match not blocked");
    a_irq_masked: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        irq_out[1] |-> mask_q[1] && flag_q[1])
        else $error("irq unmasked");
    a_normal_wrap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (wave_mode_field_in == `TCU_WM_NORMAL && tick && !count_wr_in
         && count_q == `TCU_MAX) |=> count_q == `TCU_BOTTOM && flag_q[0])
        else $error("normal wrap wrong");
    a_direct_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!pwm_mode && cmp_b_wr_in && enabled)
        |=> ocr_b_q == $past(cmp_wdata_in))
        else $error("direct compare write lost");
    a_set_wins: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        flag_set[1] |=> flag_q[1]) else $error("flag set lost");
    a_com_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (cmp_b_event && compare_output_mode_b_in == `TCU_COM_NONE
         && !pwm_mode) |=> $stable(oc_b_q))
        else $error("output moved on mode zero");
endmodule

// File: verif/tcu_pin_load.sv
// External load on the two compare output pins of the timer.
// Assumes the pins float to a pull-down level until made outputs.
`timescale 1ns/1ns
module tcu_pin_load (
    input  wire logic dir_en_in,
    input  wire logic level_a_in,
    input  wire logic level_b_in,
    output logic      pin_a_out,
    output logic      pin_b_out
);
    // Undriven pin shows the pull-down, never a stale output level
    assign pin_a_out = dir_en_in ? level_a_in : 1'b0;
    assign pin_b_out = dir_en_in ? level_b_in : 1'b0;
endmodule

// File: verif/timer8_compare_unit_test.sv
// Self-checking bench for the 8-bit timer with two compare channels.
// Assumes tcu_pkg and the pin load model are compiled before it.
`timescale 1ns/1ns
`include "tcu_defs.svh"
module timer8_compare_unit_test
    import tcu_pkg::*;
;
    logic          clk_in;
    logic          rst_b_in;
    logic          pr, as_sel, osc, dir_en;
    logic [2:0]    cs, wm;
    logic [1:0]    coma, comb;
    logic [7:0]    stb;
    tcu_byte_type  wdat, cnt, cva, cvb, mx;
    tcu_flags_type flg, msk, irq;
    logic          oa, ob, pin_a, pin_b;
    int            n_mismatch = 0;
    int            n_checks = 0;
    int            k;
    logic [1:0]    com_tab [5] = '{`TCU_COM_SET, `TCU_COM_NONE,
        `TCU_COM_CLEAR, `TCU_COM_TOGGLE, `TCU_COM_SET};
    logic          exp_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

    tcu_timer8 dut (
        .clk_in                   (clk_in),
        .rst_b_in                 (rst_b_in),
        .power_reduce_bit_in      (pr),
        .async_clock_select_in    (as_sel),
        .osc_pin_in               (osc),
        .clock_select_field_in    (cs),
        .wave_mode_field_in       (wm),
        .compare_output_mode_a_in (coma),
        .compare_output_mode_b_in (comb),
        .count_wr_in              (stb[0]),
        .count_wdata_in           (wdat),
        .cmp_a_wr_in              (stb[1]),
        .cmp_b_wr_in              (stb[2]),
        .cmp_wdata_in             (wdat),
        .force_compare_strobe_a_in(stb[5]),
        .force_compare_strobe_b_in(stb[6]),
        .flag_wr_in               (stb[3]),
        .flag_wdata_in            (wdat[2:0]),
        .irq_ack_in               (wdat[2:0] & {3{stb[7]}}),
        .mask_wr_in               (stb[4]),
        .mask_wdata_in            (wdat[2:0]),
        .count_value_out          (cnt),
        .compare_value_a_out      (cva),
        .compare_value_b_out      (cvb),
        .timer_flag_reg_out       (flg),
        .timer_mask_reg_out       (msk),
        .irq_out                  (irq),
        .compare_out_a_out        (oa),
        .compare_out_b_out        (ob)
    );

    tcu_pin_load load (
        .dir_en_in (dir_en),
        .level_a_in(oa),
        .level_b_in(ob),
        .pin_a_out (pin_a),
        .pin_b_out (pin_b)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    // Strobe index: 0 count, 1/2 compare, 3 flag, 4 mask, 5/6 force, 7 ack
    task automatic wr(input int sel, input tcu_byte_type v);
        @(posedge clk_in);
        stb[sel] <= 1'b1;
        wdat     <= v;
        @(posedge clk_in);
        stb      <= 8'h00;
        @(negedge clk_in);
    endtask

    task automatic cfg(input logic [2:0] c, input logic [2:0] w,
                       input logic [1:0] a, input logic [1:0] b);
        @(posedge clk_in);
        cs   <= c;
        wm   <= w;
        coma <= a;
        comb <= b;
        @(negedge clk_in);
    endtask

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wait_cnt(input tcu_byte_type v);
        int i;
        for (i = 0; i < 600 && cnt !== v; i++) step(1);
        chk("count reached", cnt, v);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        {rst_b_in, pr, as_sel, osc, dir_en, cs, wm} = '0;
        {coma, comb, stb, wdat} = '0;
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        step(0);
        chk("count reset", cnt, 8'h00);
        chk("cmp a reset", cva, 8'h00);
        chk("flags reset", flg, 3'h0);
        chk("mask reset", msk, 3'h0);
        wr(1, 8'h05);
        wr(2, 8'h07);
        wr(4, 8'h02);
        chk("cmp a direct", cva, 8'h05);
        cfg(3'h1, `TCU_WM_NORMAL, `TCU_COM_NONE, `TCU_COM_NONE);
        wait_cnt(8'h09);
        cfg(3'h0, `TCU_WM_NORMAL, `TCU_COM_NONE, `TCU_COM_NONE);
        step(2);
        chk("match flags", flg, 3'h6);
        chk("masked irq", irq, 3'h2);
        wr(3, 8'h02);
        chk("flag clear by one", flg, 3'h4);
        wr(7, 8'h04);
        chk("flag clear by ack", flg, 3'h0);
        wr(0, 8'hfe);
        cfg(3'h1, `TCU_WM_NORMAL, `TCU_COM_NONE, `TCU_COM_NONE);
        wait_cnt(8'h00);
        step(2);
        cfg(3'h0, `TCU_WM_NORMAL, `TCU_COM_NONE, `TCU_COM_NONE);
        chk("overflow flag", flg, 3'h1);
        chk("ovf irq masked", irq, 3'h0);
        wr(4, 8'h01);
        chk("ovf irq enabled", irq, 3'h1);
        wr(3, 8'h01);
        wr(1, 8'h20);
        wr(0, 8'h20);
        wr(3, 8'h07);
        cfg(3'h1, `TCU_WM_NORMAL, `TCU_COM_NONE, `TCU_COM_NONE);
        step(3);
        cfg(3'h0, `TCU_WM_NORMAL, `TCU_COM_NONE, `TCU_COM_NONE);
        chk("blocked match", flg, 3'h0);
        wr(0, 8'h33);
        for (k = 0; k < 5; k++) begin
            cfg(3'h0, `TCU_WM_CTC, com_tab[k], com_tab[k]);
            wr(5, 8'h00);
            wr(6, 8'h00);
            chk("forced out a", oa, exp_tab[k]);
            chk("forced out b", ob, exp_tab[k]);
        end
        chk("force no flag", flg, 3'h0);
        chk("force no clear", cnt, 8'h33);
        chk("pin before enable", pin_a, 1'b0);
        @(posedge clk_in);
        dir_en <= 1'b1;
        step(0);
        chk("pin after enable", pin_a, 1'b1);
        chk("pin b after enable", pin_b, 1'b1);
        wr(1, 8'h03);
        wr(0, 8'h00);
        cfg(3'h1, `TCU_WM_CTC, `TCU_COM_NONE, `TCU_COM_NONE);
        mx = 8'h00;
        for (k = 0; k < 12; k++) begin
            step(1);
            if (cnt > mx) mx = cnt;
        end
        cfg(3'h0, `TCU_WM_CTC, `TCU_COM_NONE, `TCU_COM_NONE);
        chk("ctc top", mx, 8'h03);
        chk("ctc flag a", flg[1], 1'b1);
        cfg(3'h0, `TCU_WM_FPWM, `TCU_COM_NONE, `TCU_COM_NONE);
        chk("out kept on mode", oa, 1'b1);
        wr(2, 8'h0c);
        chk("cmp b buffer", cvb, 8'h0c);
        wr(0, 8'h05);
        wr(3, 8'h07);
        cfg(3'h1, `TCU_WM_FPWM, `TCU_COM_NONE, `TCU_COM_NONE);
        wait_cnt(8'h08);
        cfg(3'h0, `TCU_WM_FPWM, `TCU_COM_NONE, `TCU_COM_NONE);
        step(2);
        chk("old active cmp b", flg, 3'h4);
        // Dual slope with top from channel A: 0,1,2,3,2,1,0 and on
        cfg(3'h0, `TCU_WM_PCPWM_A, `TCU_COM_NONE, `TCU_COM_NONE);
        wr(0, 8'h00);
        wr(3, 8'h07);
        cfg(3'h1, `TCU_WM_PCPWM_A, `TCU_COM_NONE, `TCU_COM_NONE);
        mx = 8'h00;
        for (k = 0; k < 10; k++) begin
            step(1);
            if (cnt > mx) mx = cnt;
        end
        cfg(3'h0, `TCU_WM_PCPWM_A, `TCU_COM_NONE, `TCU_COM_NONE);
        chk("dual slope top", mx, 8'h03);
        chk("ovf at bottom", flg[0], 1'b1);
        @(posedge clk_in);
        as_sel <= 1'b1;
        wr(0, 8'h00);
        cfg(3'h1, `TCU_WM_NORMAL, `TCU_COM_NONE, `TCU_COM_NONE);
        step(8);
        chk("no osc no tick", cnt, 8'h00);
        repeat (3) begin
            @(posedge clk_in);
            osc <= 1'b1;
            step(3);
            @(posedge clk_in);
            osc <= 1'b0;
            step(3);
        end
        step(4);
        chk("osc ticks", cnt, 8'h03);
        cfg(3'h0, `TCU_WM_NORMAL, `TCU_COM_NONE, `TCU_COM_NONE);
        @(posedge clk_in);
        as_sel <= 1'b0;
        pr     <= 1'b1;
        wr(0, 8'h55);
        chk("write while idle", cnt, 8'h03);
        @(posedge clk_in);
        pr <= 1'b0;
        step(5);
        chk("stopped count", cnt, 8'h03);
        cfg(3'h1, `TCU_WM_NORMAL, `TCU_COM_NONE, `TCU_COM_NONE);
        wr(0, 8'h80);
        chk("write beats count", cnt, 8'h80);
        wrap_up();
    end
endmodule
